// [i2cms_pkg.sv]
// Constants and state types of the I2C master sequencer.
// Assumes one 200 MHz clock and a plain 8-bit register port.
package i2cms_pkg;

    // Register byte addresses
    localparam logic [7:0] ADDR_SEQ_CTRL = 8'h00;
    localparam logic [7:0] ADDR_BUS_STATUS = 8'h04;
    localparam logic [7:0] ADDR_EVENT_FLAGS = 8'h08;
    localparam logic [7:0] ADDR_SHIFT_BUF = 8'h0C;
    localparam logic [7:0] ADDR_RATE_RELOAD = 8'h10;

    // Sequence control bits
    localparam int SEQ_START = 0;
    localparam int SEQ_RESTART = 1;
    localparam int SEQ_RECEIVE = 3;
    localparam int SEQ_ACK_REQ = 4;
    localparam int SEQ_ACK_VAL = 5;
    localparam int SEQ_ACK_RCVD = 6;
    localparam logic [4:0] SEQ_REQ_MASK = 5'h1B;

    // Bus status bits
    localparam int STAT_BUF_FULL = 0;
    localparam int STAT_START_DET = 3;

    // Event flag bits
    localparam int FLAG_EVENT = 0;
    localparam int FLAG_COLL = 1;
    localparam int FLAG_WRITE_COLLISION_FLAG = 2;
    localparam int FLAG_OVF = 3;

    // Reset values
    localparam logic [7:0] RST_SEQ = 8'h00;
    localparam logic [7:0] RST_RATE = 8'h00;
    localparam logic [7:0] RST_BUF = 8'h00;
    localparam logic [3:0] RST_FLAGS = 4'h0;

    // Bits in one byte
    localparam logic [3:0] BYTE_BITS = 4'h8;

    typedef enum logic [4:0] {
        ST_IDLE,
        ST_START_WAIT,
        ST_START_HOLD,
        ST_RS_LOW,
        ST_RS_REL,
        ST_RS_SCLHI,
        ST_RS_HIGH,
        ST_RS_SDALOW,
        ST_TX_LOW,
        ST_TX_WAITH,
        ST_TX_HIGH,
        ST_RX_LOW,
        ST_RX_WAITH,
        ST_RX_HIGH,
        ST_ACK_LOW,
        ST_ACK_WAITH,
        ST_ACK_HIGH
    } i2cms_fsm_t;

    typedef struct packed {
        i2cms_fsm_t state;
        logic [6:0] brg_cnt;
        logic brg_run;
        logic scl_low;
        logic sda_low;
        logic scl_m;
        logic scl_s;
        logic sda_m;
        logic sda_s;
        logic [7:0] seq;
        logic [3:0] flags;
        logic bf;
        logic start_det;
        logic [7:0] buffer;
        logic [7:0] sr;
        logic [3:0] bitcnt;
        logic [7:0] rate;
        logic [7:0] rdata;
    } i2cms_regs_t;

endpackage

// [i2cms_slave.sv]
// Slave model: counts SCL edges, acknowledges or sends a byte.
// Assumes open-drain wires resolved in the bench, pulled up.
`timescale 1ns/1ps
module i2cms_slave (
    // Control
    input wire logic clk,
    input wire logic arm,
    input wire logic rx_mode,
    input wire logic ack_low,
    input wire logic [7:0] tx_byte,
    // Bus wires and received byte
    input wire logic scl,
    input wire logic sda,
    output logic sda_oe,
    output logic [7:0] got
);
    logic scl_q = 1'b1;
    int cnt = 0;
    initial sda_oe = 1'b0;
    initial got = 8'h00;
    always @(posedge clk) begin
        scl_q <= scl;
        if (arm) begin
            cnt <= 0;
            sda_oe <= rx_mode & ~tx_byte[7];
        end else if (scl && !scl_q) begin
            if (cnt < 8)
                got <= {got[6:0], sda};
            cnt <= cnt + 1;
        end else if (!scl && scl_q) begin
            if (!rx_mode)
                sda_oe <= (cnt == 8) & ack_low;
            else
                sda_oe <= (cnt < 8) ? ~tx_byte[3'(7 - cnt)] : 1'b0;
        end
    end
endmodule // i2cms_slave

// [i2cms_tb.sv]
// Bench for the I2C master sequencer with a slave model.
// Assumes the package register map; other masters are mimicked.
`timescale 1ns/1ps
module testbench;
    import i2cms_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata, got;
    logic scl_oe, sda_oe, s_oe;
    logic scl_o, sda_o;
    logic arm = 1'b0;
    logic rx_mode = 1'b0;
    logic ack_low = 1'b1;
    logic hold_sda = 1'b0;
    logic [7:0] tx_byte = 8'hFF;
    // Pulled-up wires, low if anyone pulls
    wire scl = (scl_oe !== 1'b1);
    wire sda = !(sda_oe === 1'b1 || s_oe || hold_sda);
    int bad_count = 0;
    int check_count = 0;
    i2cms_top i_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .scl_in(scl), .scl_out(scl_o),
        .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_o), .sda_oe(sda_oe));
    i2cms_slave i_slave (.clk(clk), .arm(arm), .rx_mode(rx_mode),
        .ack_low(ack_low), .tx_byte(tx_byte), .scl(scl), .sda(sda),
        .sda_oe(s_oe), .got(got));
    initial begin
        forever #2.5 clk = ~clk;
    end
    task automatic ck(input string n, input logic [7:0] s, e);
        check_count++;
        if (s !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wreg(input logic [7:0] a, d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic cr(input logic [7:0] a, m, e, input string n);
        logic [7:0] d;
        rreg(a, d);
        ck(n, d & m, e);
    endtask
    // Poll a bit; a slow design is cut short
    task automatic wt(input logic [7:0] a, input int b, input logic v);
        logic [7:0] d;
        int k;
        k = 0;
        do begin
            rreg(a, d);
            k++;
        end while (d[b] !== v && k < 500);
        if (k >= 500)
            ck("wait", d[b], v);
    endtask
    task automatic pins(input logic [7:0] e);
        // Open-drain data outputs must stay low
        #1 ck("pins", {4'h0, scl_o, sda_o, scl_oe, sda_oe}, e);
    endtask
    task automatic go(input logic rx, input logic [7:0] b);
        rx_mode <= rx;
        tx_byte <= b;
        arm <= 1'b1;
        @(posedge clk);
        arm <= 1'b0;
    endtask
    task automatic results;
        $display("checks %0d errors %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (50000) @(posedge clk);
        bad_count++;
        results;
    end
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        cr(ADDR_SEQ_CTRL, 8'hFF, RST_SEQ, "seq");
        cr(ADDR_BUS_STATUS, 8'hFF, 8'h00, "stat");
        cr(ADDR_EVENT_FLAGS, 8'hFF, {4'h0, RST_FLAGS}, "flags");
        cr(8'h14, 8'hFF, 8'h00, "unmapped");
        wreg(ADDR_RATE_RELOAD, 8'h0C);
        cr(ADDR_RATE_RELOAD, 8'hFF, 8'h0C, "rate");
        // Start while another party holds SDA low
        hold_sda <= 1'b1;
        wreg(ADDR_SEQ_CTRL, 8'h01);
        repeat (40) @(posedge clk);
        cr(ADDR_EVENT_FLAGS, 8'h02, 8'h02, "coll");
        cr(ADDR_SEQ_CTRL, 8'h1F, 8'h00, "seq");
        hold_sda <= 1'b0;
        wreg(ADDR_EVENT_FLAGS, 8'h00);
        wreg(ADDR_SEQ_CTRL, 8'h01);
        repeat (8) @(posedge clk);
        pins(8'h00);
        wreg(ADDR_SHIFT_BUF, 8'h55);
        wreg(ADDR_SEQ_CTRL, 8'h08);
        cr(ADDR_SEQ_CTRL, 8'h1F, 8'h01, "seq");
        wt(ADDR_SEQ_CTRL, SEQ_START, 1'b0);
        pins(8'h01);
        cr(ADDR_BUS_STATUS, 8'h08, 8'h08, "sdet");
        cr(ADDR_EVENT_FLAGS, 8'h04, 8'h04, "write_collision_flag");
        cr(ADDR_SHIFT_BUF, 8'hFF, 8'h00, "buf");
        // Acked byte, then refused byte
        for (int i = 0; i < 2; i++) begin
            wreg(ADDR_EVENT_FLAGS, 8'h00);
            ack_low <= (i == 0);
            go(1'b0, 8'hFF);
            wreg(ADDR_SHIFT_BUF, i ? 8'h3C : 8'hA6);
            cr(ADDR_BUS_STATUS, 8'h01, 8'h01, "bf");
            wreg(ADDR_SHIFT_BUF, 8'h00);
            wreg(ADDR_SEQ_CTRL, 8'h08);
            wt(ADDR_EVENT_FLAGS, FLAG_EVENT, 1'b1);
            pins(8'h02);
            ck("sent", got, i ? 8'h3C : 8'hA6);
            cr(ADDR_SEQ_CTRL, 8'h5F, i ? 8'h40 : 8'h00,
               "ack");
            cr(ADDR_BUS_STATUS, 8'h01, 8'h00, "bf");
            cr(ADDR_EVENT_FLAGS, 8'h04, 8'h04, "write_collision_flag");
        end
        // Three receives, the last into a full buffer
        for (int i = 0; i < 3; i++) begin
            go(1'b1, i ? 8'h5A : 8'hC3);
            wreg(ADDR_EVENT_FLAGS, 8'h00);
            wreg(ADDR_SEQ_CTRL, 8'h08);
            wreg(ADDR_SHIFT_BUF, 8'h77);
            wt(ADDR_EVENT_FLAGS, FLAG_EVENT, 1'b1);
            pins(8'h02);
            cr(ADDR_SEQ_CTRL, 8'h08, 8'h00, "rcv");
            cr(ADDR_BUS_STATUS, 8'h01, 8'h01, "bf");
            cr(ADDR_EVENT_FLAGS, 8'h0C, i == 2 ? 8'h0C : 8'h04,
               "ovf");
            if (i == 0) begin
                cr(ADDR_SHIFT_BUF, 8'hFF, 8'hC3, "rx");
                cr(ADDR_BUS_STATUS, 8'h01, 8'h00, "bf");
            end
        end
        // Acknowledge low, then high
        for (int i = 0; i < 2; i++) begin
            wreg(ADDR_EVENT_FLAGS, 8'h00);
            wreg(ADDR_SEQ_CTRL, i ? 8'h20 : 8'h00);
            wreg(ADDR_SEQ_CTRL, i ? 8'h30 : 8'h10);
            wreg(ADDR_SHIFT_BUF, 8'h11);
            #1 ck("ackpin", {7'h0, sda_oe}, i ? 8'h00 : 8'h01);
            wt(ADDR_SEQ_CTRL, SEQ_ACK_REQ, 1'b0);
            #1 ck("ackscl", {7'h0, scl_oe}, 8'h01);
            cr(ADDR_EVENT_FLAGS, 8'h05, 8'h05, "ackend");
        end
        // Repeated start, writes refused meanwhile
        wreg(ADDR_EVENT_FLAGS, 8'h00);
        wreg(ADDR_SEQ_CTRL, 8'h02);
        wreg(ADDR_SHIFT_BUF, 8'h22);
        wreg(ADDR_SEQ_CTRL, 8'h00);
        cr(ADDR_SEQ_CTRL, 8'h02, 8'h02, "rs");
        wt(ADDR_SEQ_CTRL, SEQ_RESTART, 1'b0);
        #1 ck("rssda", {7'h0, sda_oe}, 8'h01);
        wt(ADDR_EVENT_FLAGS, FLAG_EVENT, 1'b1);
        cr(ADDR_EVENT_FLAGS, 8'h06, 8'h04, "rsflags");
        cr(ADDR_BUS_STATUS, 8'h08, 8'h08, "sdet");
        // Repeated start with SDA held low elsewhere
        wreg(ADDR_EVENT_FLAGS, 8'h00);
        hold_sda <= 1'b1;
        wreg(ADDR_SEQ_CTRL, 8'h02);
        repeat (60) @(posedge clk);
        cr(ADDR_EVENT_FLAGS, 8'h02, 8'h02, "rscoll");
        cr(ADDR_SEQ_CTRL, 8'h02, 8'h00, "rs");
        hold_sda <= 1'b0;
        results;
    end
endmodule // testbench

// [i2cms_top.sv]
// I2C master sequencer: start, repeated start, byte send and
// receive, acknowledge, paced by a reloadable rate generator.
// Assumes open-drain pads resolved outside and a plain register port.
`timescale 1ns/1ps

module i2cms_top
    import i2cms_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // Serial clock line
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    // Serial data line
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe
);

    i2cms_regs_t q;
    i2cms_regs_t next_q;
    logic tmo;
    logic idle;
    logic pending;
    logic in_tx;

    function automatic i2cms_regs_t load_brg(i2cms_regs_t s,
                                             logic [6:0] v);
        i2cms_regs_t r;
        r = s;
        r.brg_cnt = v;
        r.brg_run = 1'b1;
        return r;
    endfunction

    // Collision: drop requests, free both lines, back to idle
    function automatic i2cms_regs_t abort(i2cms_regs_t s);
        i2cms_regs_t r;
        r = s;
        r.flags[FLAG_COLL] = 1'b1;
        r.seq[4:0] = 5'h00;
        r.scl_low = 1'b0;
        r.sda_low = 1'b0;
        r.brg_run = 1'b0;
        r.state = ST_IDLE;
        return r;
    endfunction

    assign tmo = q.brg_run && (q.brg_cnt == 7'h00);
    assign idle = (q.state == ST_IDLE);
    assign pending = |(q.seq[4:0] & SEQ_REQ_MASK);
    assign in_tx = (q.state == ST_TX_LOW) || (q.state == ST_TX_WAITH)
                   || (q.state == ST_TX_HIGH);

    always_comb begin
        next_q = q;
        // Two-stage pin synchronisers
        next_q.scl_m = scl_in;
        next_q.scl_s = q.scl_m;
        next_q.sda_m = sda_in;
        next_q.sda_s = q.sda_m;

        if (q.brg_run) begin
            if (q.brg_cnt == 7'h00) begin
                next_q.brg_run = 1'b0;
            end else begin
                next_q.brg_cnt = q.brg_cnt - 7'h01;
            end
        end

        // Register reads, data one cycle later
        if (rd) begin
            next_q.rdata = 8'h00;
            case (addr)
                ADDR_SEQ_CTRL: next_q.rdata = q.seq;
                ADDR_BUS_STATUS: begin
                    next_q.rdata[STAT_BUF_FULL] = q.bf;
                    next_q.rdata[STAT_START_DET] = q.start_det;
                end
                ADDR_EVENT_FLAGS: next_q.rdata[3:0] = q.flags;
                ADDR_SHIFT_BUF: begin
                    next_q.rdata = q.buffer;
                    if (!in_tx) begin
                        next_q.bf = 1'b0;
                    end
                end
                ADDR_RATE_RELOAD: next_q.rdata = q.rate;
                default: next_q.rdata = 8'h00;
            endcase
        end

        // Register writes; hardware sets below win over these
        if (wr) begin
            case (addr)
                ADDR_SEQ_CTRL: begin
                    next_q.seq[SEQ_ACK_VAL] = wdata[SEQ_ACK_VAL];
                    if (idle && !pending) begin
                        next_q.seq[4:0] = wdata[4:0] & SEQ_REQ_MASK;
                    end
                end
                ADDR_EVENT_FLAGS: next_q.flags = wdata[3:0];
                ADDR_SHIFT_BUF: begin
                    if (idle && !pending) begin
                        next_q.buffer = wdata;
                        next_q.sr = wdata;
                        next_q.bf = 1'b1;
                        next_q.bitcnt = 4'h0;
                        next_q.scl_low = 1'b1;
                        next_q.sda_low = !wdata[7];
                        next_q = load_brg(next_q, q.rate[6:0]);
                        next_q.state = ST_TX_LOW;
                    end else begin
                        next_q.flags[FLAG_WRITE_COLLISION_FLAG] = 1'b1;
                    end
                end
                ADDR_RATE_RELOAD: next_q.rate = wdata;
                default: ;
            endcase
        end

        case (q.state)
            ST_IDLE: begin
                if (q.seq[SEQ_START]) begin
                    if (q.sda_s && q.scl_s) begin
                        next_q = load_brg(next_q, q.rate[6:0]);
                        next_q.state = ST_START_WAIT;
                    end else begin
                        next_q = abort(next_q);
                    end
                end else if (q.seq[SEQ_RESTART]) begin
                    next_q.scl_low = 1'b1;
                    next_q.state = ST_RS_LOW;
                end else if (q.seq[SEQ_ACK_REQ]) begin
                    next_q.scl_low = 1'b1;
                    next_q.sda_low = !q.seq[SEQ_ACK_VAL];
                    next_q = load_brg(next_q, q.rate[6:0]);
                    next_q.state = ST_ACK_LOW;
                end else if (q.seq[SEQ_RECEIVE]) begin
                    next_q.scl_low = 1'b1;
                    next_q.sda_low = 1'b0;
                    next_q.sr = 8'h00;
                    next_q.bitcnt = 4'h0;
                    next_q = load_brg(next_q, q.rate[6:0]);
                    next_q.state = ST_RX_LOW;
                end
            end
            ST_START_WAIT: begin
                if (!q.scl_s) begin
                    next_q = abort(next_q);
                end else if (tmo) begin
                    if (q.sda_s) begin
                        next_q.sda_low = 1'b1;
                        next_q.start_det = 1'b1;
                        next_q = load_brg(next_q, q.rate[6:0]);
                        next_q.state = ST_START_HOLD;
                    end else begin
                        next_q = abort(next_q);
                    end
                end
            end
            ST_START_HOLD: begin
                if (tmo) begin
                    next_q.seq[SEQ_START] = 1'b0;
                    next_q.state = ST_IDLE;
                end
            end
            ST_RS_LOW: begin
                // Six-bit reload once SCL is low
                if (!q.scl_s) begin
                    next_q.sda_low = 1'b0;
                    next_q = load_brg(next_q, {1'b0, q.rate[5:0]});
                    next_q.state = ST_RS_REL;
                end
            end
            ST_RS_REL: begin
                // Release SCL if SDA came high
                if (tmo) begin
                    if (q.sda_s) begin
                        next_q.scl_low = 1'b0;
                        next_q.state = ST_RS_SCLHI;
                    end else begin
                        next_q = abort(next_q);
                    end
                end
            end
            ST_RS_SCLHI: begin
                if (q.scl_s) begin
                    if (!q.sda_s) begin
                        next_q = abort(next_q);
                    end else begin
                        next_q = load_brg(next_q, q.rate[6:0]);
                        next_q.state = ST_RS_HIGH;
                    end
                end
            end
            ST_RS_HIGH: begin
                if (!q.scl_s) begin
                    next_q = abort(next_q);
                end else if (tmo) begin
                    next_q.sda_low = 1'b1;
                    next_q.start_det = 1'b1;
                    next_q = load_brg(next_q, q.rate[6:0]);
                    next_q.state = ST_RS_SDALOW;
                end
            end
            ST_RS_SDALOW: begin
                if (tmo) begin
                    next_q.seq[SEQ_RESTART] = 1'b0;
                    next_q.flags[FLAG_EVENT] = 1'b1;
                    next_q.state = ST_IDLE;
                end
            end
            ST_TX_LOW: begin
                if (tmo) begin
                    next_q.scl_low = 1'b0;
                    next_q.state = ST_TX_WAITH;
                end
            end
            ST_TX_WAITH: begin
                // High time counts from SCL seen high
                if (q.scl_s) begin
                    next_q = load_brg(next_q, q.rate[6:0]);
                    next_q.state = ST_TX_HIGH;
                end
            end
            ST_TX_HIGH: begin
                if (tmo) begin
                    next_q.scl_low = 1'b1;
                    if (q.bitcnt == BYTE_BITS) begin
                        next_q.seq[SEQ_ACK_RCVD] = q.sda_s;
                        next_q.flags[FLAG_EVENT] = 1'b1;
                        next_q.state = ST_IDLE;
                    end else begin
                        next_q.bitcnt = q.bitcnt + 4'h1;
                        next_q.sr = {q.sr[6:0], 1'b0};
                        if (q.bitcnt == BYTE_BITS - 4'h1) begin
                            next_q.bf = 1'b0;
                            next_q.sda_low = 1'b0;
                        end else begin
                            next_q.sda_low = !q.sr[6];
                        end
                        next_q = load_brg(next_q, q.rate[6:0]);
                        next_q.state = ST_TX_LOW;
                    end
                end
            end
            ST_RX_LOW: begin
                if (tmo) begin
                    next_q.scl_low = 1'b0;
                    next_q.state = ST_RX_WAITH;
                end
            end
            ST_RX_WAITH: begin
                if (q.scl_s) begin
                    next_q = load_brg(next_q, q.rate[6:0]);
                    next_q.state = ST_RX_HIGH;
                end
            end
            ST_RX_HIGH: begin
                if (tmo) begin
                    next_q.scl_low = 1'b1;
                    next_q.sr = {q.sr[6:0], q.sda_s};
                    if (q.bitcnt == BYTE_BITS - 4'h1) begin
                        next_q.seq[SEQ_RECEIVE] = 1'b0;
                        next_q.buffer = {q.sr[6:0], q.sda_s};
                        if (q.bf) begin
                            next_q.flags[FLAG_OVF] = 1'b1;
                        end
                        next_q.bf = 1'b1;
                        next_q.flags[FLAG_EVENT] = 1'b1;
                        next_q.state = ST_IDLE;
                    end else begin
                        next_q.bitcnt = q.bitcnt + 4'h1;
                        next_q = load_brg(next_q, q.rate[6:0]);
                        next_q.state = ST_RX_LOW;
                    end
                end
            end
            ST_ACK_LOW: begin
                if (tmo) begin
                    next_q.scl_low = 1'b0;
                    next_q.state = ST_ACK_WAITH;
                end
            end
            ST_ACK_WAITH: begin
                if (q.scl_s) begin
                    next_q = load_brg(next_q, q.rate[6:0]);
                    next_q.state = ST_ACK_HIGH;
                end
            end
            ST_ACK_HIGH: begin
                if (tmo) begin
                    next_q.scl_low = 1'b1;
                    next_q.seq[SEQ_ACK_REQ] = 1'b0;
                    next_q.flags[FLAG_EVENT] = 1'b1;
                    next_q.state = ST_IDLE;
                end
            end
            default: next_q.state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
            q.seq <= RST_SEQ;
            q.rate <= RST_RATE;
            q.buffer <= RST_BUF;
            q.flags <= RST_FLAGS;
        end else begin
            q <= next_q;
        end
    end

    // Open drain: pull low or release
    assign scl_out = 1'b0;
    assign scl_oe = q.scl_low;
    assign sda_out = 1'b0;
    assign sda_oe = q.sda_low;
    assign rdata = q.rdata;

    a_start_load: assert property (
        @(posedge clk) disable iff (rst)
        (idle && q.seq[SEQ_START] && q.sda_s && q.scl_s)
        |=> (q.state == ST_START_WAIT && q.brg_run
             && q.brg_cnt == $past(q.rate[6:0])))
        else $error("start did not load rate generator");

    a_start_sda_low: assert property (
        @(posedge clk) disable iff (rst)
        (q.state == ST_START_WAIT && tmo && q.sda_s && q.scl_s)
        |=> (sda_oe && q.start_det && q.state == ST_START_HOLD))
        else $error("start condition not driven");

    a_start_done: assert property (
        @(posedge clk) disable iff (rst)
        (q.state == ST_START_HOLD && tmo)
        |=> (!q.seq[SEQ_START] && idle && sda_oe && !q.brg_run))
        else $error("start did not complete");

    a_start_coll: assert property (
        @(posedge clk) disable iff (rst)
        (q.state == ST_START_WAIT && !q.scl_s)
        |=> (q.flags[FLAG_COLL] && idle && !sda_oe && !scl_oe))
        else $error("start collision missed");

    a_tx_write_collision_flag: assert property (
        @(posedge clk) disable iff (rst)
        (wr && addr == ADDR_SHIFT_BUF && in_tx)
        |=> (q.flags[FLAG_WRITE_COLLISION_FLAG] && q.buffer == $past(q.buffer)))
        else $error("busy buffer write not refused");

    a_ack_sample: assert property (
        @(posedge clk) disable iff (rst)
        (q.state == ST_TX_HIGH && tmo && q.bitcnt == BYTE_BITS)
        |=> (q.seq[SEQ_ACK_RCVD] == $past(q.sda_s)
             && q.flags[FLAG_EVENT] && scl_oe && !sda_oe))
        else $error("acknowledge not recorded");

    a_rx_done: assert property (
        @(posedge clk) disable iff (rst)
        (q.state == ST_RX_HIGH && tmo && q.bitcnt == BYTE_BITS - 4'h1)
        |=> (q.bf && q.flags[FLAG_EVENT] && !q.seq[SEQ_RECEIVE]
             && idle && scl_oe))
        else $error("receive end not handled");

    a_brg_count: assert property (
        @(posedge clk) disable iff (rst)
        (q.brg_run && q.brg_cnt != 7'h00)
        |=> (q.brg_cnt == $past(q.brg_cnt) - 7'h01))
        else $error("rate generator did not count down");

endmodule // i2cms_top
